//--- pseq_power_sequence_control.v
// power-up gating and mirror array shutdown sequencer
//
// Behaviour
// - The controller leaves reset only once supply-good is high.
// - For 60 ms after power-on sense rises, supply-good is ignored.
// - A supply-good drop starts the shutdown sequence inside the 20 ms hold window.
// - Shutdown does memory loads to the mirror array, then the park instruction.
`include "pseq_consts.vh"

// window lengths default to the real timing; a bench may shorten them
module pseq_power_sequence_control #(
	parameter [`PSEQ_CNT_W-1:0] IGNORE_CYC = `PSEQ_IGNORE_CYC,
	parameter [`PSEQ_CNT_W-1:0] HOLD_CYC   = `PSEQ_HOLD_CYC
) (
	input  wire                     clk_sys,
	input  wire                     rst_n,
	input  wire                     supply_good_in,
	input  wire                     power_on_sense_in,
	input  wire                     mode_valid,
	input  wire [`PSEQ_MODE_W-1:0]  mode_value,
	input  wire                     mirror_ack,
	output reg                      core_rst_n,
	output reg                      mirror_load_req,
	output reg                      mirror_park_req,
	output reg                      shutdown_busy,
	output reg                      shutdown_done,
	output reg                      hold_expired
);
	localparam [2:0] ST_OFF   = 3'h0;
	localparam [2:0] ST_WAIT  = 3'h1;
	localparam [2:0] ST_RUN   = 3'h2;
	localparam [2:0] ST_LOAD  = 3'h3;
	localparam [2:0] ST_PARK  = 3'h4;
	localparam [2:0] ST_PARKD = 3'h5;

	localparam [`PSEQ_LOAD_W-1:0] LOAD_LAST = `PSEQ_LOAD_LAST;

	wire pg_s;
	wire ps_s;

	pseq_sync2 u_sync_pg (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d_in    (supply_good_in),
		.q_out   (pg_s)
	);

	pseq_sync2 u_sync_ps (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d_in    (power_on_sense_in),
		.q_out   (ps_s)
	);

	reg  [2:0]              state_r;
	reg  [2:0]              state_nxt;
	reg  [`PSEQ_CNT_W-1:0]  ign_cnt_r;
	reg  [`PSEQ_CNT_W-1:0]  hold_cnt_r;
	reg  [`PSEQ_LOAD_W-1:0] load_cnt_r;
	reg                     ps_d_r;
	reg                     pg_drop_r;

	function [`PSEQ_CNT_W-1:0] dec_sat;
		input [`PSEQ_CNT_W-1:0] v;
		begin
			dec_sat = (v == {`PSEQ_CNT_W{1'b0}}) ? v : v - 1'b1;
		end
	endfunction

	wire ps_rise    = ps_s & ~ps_d_r;
	wire ign_active = (ign_cnt_r != {`PSEQ_CNT_W{1'b0}});
	wire pg_eff     = pg_s & ~ign_active;
	wire standby    = mode_valid & (mode_value == `PSEQ_MODE_STANDBY);

	// ignore window counter restarts at each power-on sense rise
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ps_d_r    <= 1'b0;
			ign_cnt_r <= {`PSEQ_CNT_W{1'b0}};
		end else begin
			ps_d_r <= ps_s;
			if (ps_rise)
				ign_cnt_r <= IGNORE_CYC;
			else if (!ps_s)
				ign_cnt_r <= {`PSEQ_CNT_W{1'b0}};
			else
				ign_cnt_r <= dec_sat(ign_cnt_r);
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: begin
				if (ps_s)
					state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (!ps_s)
					state_nxt = ST_OFF;
				else if (pg_eff)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (!ps_s)
					state_nxt = ST_OFF;
				else if (standby || (!pg_s && !ign_active))
					state_nxt = ST_LOAD;
			end
			ST_LOAD: begin
				if (mirror_ack && load_cnt_r == LOAD_LAST)
					state_nxt = ST_PARK;
			end
			ST_PARK: begin
				if (mirror_ack)
					state_nxt = ST_PARKD;
			end
			ST_PARKD: begin
				if (!ps_s)
					state_nxt = ST_OFF;
			end
			default: state_nxt = ST_OFF;
		endcase
	end

	// load and park both count as a shutdown in flight
	function in_shutdown;
		input [2:0] st;
		begin
			in_shutdown = (st == ST_LOAD) || (st == ST_PARK);
		end
	endfunction

	wire start_sd = (state_r == ST_RUN) && (state_nxt == ST_LOAD);
	wire to_off   = (state_nxt == ST_OFF);
	wire hold_out = (hold_cnt_r == {`PSEQ_CNT_W{1'b0}});

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// load count and hold window, both armed as shutdown starts
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			load_cnt_r <= {`PSEQ_LOAD_W{1'b0}};
			hold_cnt_r <= {`PSEQ_CNT_W{1'b0}};
		end else if (start_sd) begin
			load_cnt_r <= {`PSEQ_LOAD_W{1'b0}};
			hold_cnt_r <= HOLD_CYC;
		end else begin
			if (state_r == ST_LOAD && mirror_ack) begin
				load_cnt_r <= load_cnt_r + 1'b1;
			end
			hold_cnt_r <= dec_sat(hold_cnt_r);
		end
	end

	// a supply drop that starts the shutdown puts the hold window in force, unless standby starts it in the same cycle
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pg_drop_r <= 1'b0;
		end else if (to_off) begin
			pg_drop_r <= 1'b0;
		end else if (start_sd) begin
			pg_drop_r <= ~standby;
		end
	end

	// deadline flag: supply-drop shutdown not parked before the window ran out
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hold_expired <= 1'b0;
		end else if (to_off) begin
			hold_expired <= 1'b0;
		end else if (pg_drop_r && in_shutdown(state_r) && hold_out) begin
			hold_expired <= 1'b1;
		end
	end

	// core reset follows the run state and is kept through shutdown
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_rst_n <= 1'b0;
		end else if (state_nxt == ST_RUN) begin
			core_rst_n <= 1'b1;
		end else if (!in_shutdown(state_nxt) && state_nxt != ST_PARKD) begin
			core_rst_n <= 1'b0;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mirror_load_req <= 1'b0;
			mirror_park_req <= 1'b0;
		end else begin
			mirror_load_req <= (state_nxt == ST_LOAD);
			mirror_park_req <= (state_nxt == ST_PARK);
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shutdown_busy <= 1'b0;
			shutdown_done <= 1'b0;
		end else begin
			shutdown_busy <= in_shutdown(state_nxt);
			shutdown_done <= (state_nxt == ST_PARKD);
		end
	end
endmodule

//--- pseq_consts.vh
// constants for the power sequence controller
`ifndef PSEQ_CONSTS_VH
`define PSEQ_CONSTS_VH
`define PSEQ_CLK_MHZ          125
`define PSEQ_IGNORE_MS        60
// 60 ms at 125 MHz, sized to the counter width
`define PSEQ_IGNORE_CYC       24'h7270e0
`define PSEQ_HOLD_MS          20
// 20 ms at 125 MHz, sized to the counter width
`define PSEQ_HOLD_CYC         24'h2625a0
`define PSEQ_CNT_W            24
`define PSEQ_LOAD_COUNT       8
`define PSEQ_LOAD_LAST        4'h7
`define PSEQ_LOAD_W           4
`define PSEQ_MODE_W           2
`define PSEQ_MODE_STANDBY     2'h1
`endif

//--- pseq_sync2.v
// two-flop synchroniser for a single pin level
module pseq_sync2 (
	input  wire clk_sys,
	input  wire rst_n,
	input  wire d_in,
	output wire q_out
);
	reg meta_r;
	reg q_r;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q_r    <= 1'b0;
		end else begin
			meta_r <= d_in;
			q_r    <= meta_r;
		end
	end

	assign q_out = q_r;
endmodule

//--- pseq_power_sequence_control_props.sv
// assertions on the power sequence controller ports
`include "pseq_consts.vh"
module pseq_props (
	input wire                    clk_sys,
	input wire                    rst_n,
	input wire                    supply_good_in,
	input wire                    power_on_sense_in,
	input wire                    mode_valid,
	input wire [`PSEQ_MODE_W-1:0] mode_value,
	input wire                    mirror_ack,
	input wire                    core_rst_n,
	input wire                    mirror_load_req,
	input wire                    mirror_park_req,
	input wire                    shutdown_busy,
	input wire                    shutdown_done,
	input wire                    hold_expired
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	rst_exit_a: assert property ($rose(core_rst_n) |-> $past(supply_good_in, 3))
		else $error("core reset left without supply good");
	ign_win_a: assert property ($rose(power_on_sense_in) |=> !core_rst_n [*8])
		else $error("core reset left inside ignore window");
	stby_go_a: assert property (mode_valid && mode_value == `PSEQ_MODE_STANDBY && core_rst_n
		&& !shutdown_busy && !shutdown_done |=> mirror_load_req && shutdown_busy)
		else $error("standby did not start loads");
	drop_go_a: assert property (core_rst_n && !shutdown_busy && !shutdown_done
		&& $fell(supply_good_in) |-> ##[1:4] shutdown_busy)
		else $error("supply drop did not start shutdown");
	load_excl_a: assert property (mirror_load_req |-> !mirror_park_req)
		else $error("load and park together");
	park_order_a: assert property ($rose(mirror_park_req) |-> $past(mirror_load_req))
		else $error("park without preceding loads");
	park_done_a: assert property ($fell(mirror_park_req) |-> shutdown_done && !shutdown_busy)
		else $error("park end without done");
	done_quiet_a: assert property (shutdown_done |-> !shutdown_busy && !mirror_load_req
		&& !mirror_park_req)
		else $error("done with loads or park still requested");
endmodule
bind pseq_power_sequence_control pseq_props pseq_props_inst (.clk_sys(clk_sys), .rst_n(rst_n),
	.supply_good_in(supply_good_in), .power_on_sense_in(power_on_sense_in),
	.mode_valid(mode_valid), .mode_value(mode_value), .mirror_ack(mirror_ack),
	.core_rst_n(core_rst_n), .mirror_load_req(mirror_load_req),
	.mirror_park_req(mirror_park_req), .shutdown_busy(shutdown_busy),
	.shutdown_done(shutdown_done), .hold_expired(hold_expired));

//--- pseq_mirror_model.sv
// mirror array side: acks each load or park after dly+1 cycles
module pseq_mirror_model (
	input  wire       clk_sys,
	input  wire       req,
	input  wire [3:0] dly,
	output logic      ack
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_r = 4'h0;
	initial ack = 1'b0;
	always @(posedge clk_sys) begin
		ack <= req && cnt_r == dly;
		cnt_r <= (req && cnt_r != dly) ? cnt_r + 4'h1 : 4'h0;
	end
endmodule

//--- pseq_power_sequence_control_tb.sv
// self-checking bench for the power sequence controller
`include "pseq_consts.vh"
module pseq_power_sequence_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0, rst_n = 1'b0, supply_good_in = 1'b0, power_on_sense_in = 1'b0;
	logic mode_valid = 1'b0, mirror_ack, core_rst_n, mirror_load_req, mirror_park_req;
	logic shutdown_busy, shutdown_done, hold_expired;
	logic [1:0] mode_value = 2'h0;
	logic [3:0] dly = 4'h2;
	int n_fail = 0, checked = 0, i, loads, parks;
	// shortened ignore and hold windows, scaled partner hold times
	localparam logic [23:0] IGN = 24'h0007d0, HLD = 24'h000064;
	localparam int PH = 500, WDOG_NS = 160000;
	always #4 clk_sys = ~clk_sys;
	pseq_power_sequence_control #(.IGNORE_CYC(IGN), .HOLD_CYC(HLD))
		pseq_power_sequence_control_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .supply_good_in(supply_good_in), .power_on_sense_in(power_on_sense_in),
		.mode_valid(mode_valid), .mode_value(mode_value), .mirror_ack(mirror_ack),
		.core_rst_n(core_rst_n), .mirror_load_req(mirror_load_req),
		.mirror_park_req(mirror_park_req), .shutdown_busy(shutdown_busy),
		.shutdown_done(shutdown_done), .hold_expired(hold_expired));
	pseq_mirror_model pseq_mirror_model_inst (.clk_sys(clk_sys),
		.req(mirror_load_req | mirror_park_req), .dly(dly), .ack(mirror_ack));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic mode(input logic [1:0] v);
		mode_value = v;
		mode_valid = 1'b1;
		tick(1);
		mode_valid = 1'b0;
		tick(1);
	endtask
	task automatic power_up();
		power_on_sense_in = 1'b1;
		tick(8);
		supply_good_in = 1'b1;
		tick(1000);
		chk(core_rst_n, 0);
		for (i = 0; i < IGN && !core_rst_n; i++) tick(1);
		chk(i, IGN - 1004);
		chk(core_rst_n, 1);
	endtask
	task automatic run_shutdown();
		loads = 0;
		parks = 0;
		for (i = 0; i < 400 && !shutdown_done; i++) begin
			loads += mirror_ack && mirror_load_req;
			parks += mirror_ack && mirror_park_req;
			tick(1);
		end
		chk(loads, `PSEQ_LOAD_COUNT);
		chk(parks, 1);
		chk({shutdown_done, shutdown_busy, mirror_park_req, hold_expired}, 4'h8);
	endtask
	task automatic t_standby();
		for (int v = 0; v < 4; v++) if (v != 1) mode(v[1:0]);
		tick(2);
		chk(shutdown_busy, 0);
		mode(2'h1);
		chk(mirror_load_req, 1);
		run_shutdown();
		tick(PH);
		supply_good_in = 1'b0;
		tick(PH);
		power_on_sense_in = 1'b0;
		tick(PH);
		chk(core_rst_n, 0);
	endtask
	task automatic t_drop();
		dly = 4'h5;
		power_up();
		supply_good_in = 1'b0;
		tick(4);
		chk(shutdown_busy, 1);
		run_shutdown();
		tick(HLD);
	endtask
	task automatic t_late();
		power_on_sense_in = 1'b0;
		tick(PH);
		dly = 4'hf;
		power_up();
		supply_good_in = 1'b0;
		for (i = 0; i < 400 && !shutdown_done; i++) tick(1);
		chk({shutdown_done, hold_expired}, 2'h3);
	endtask
	task automatic tally_and_finish();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		tick(2);
		rst_n = 1'b1;
		power_up();
		t_standby();
		t_drop();
		t_late();
		tally_and_finish();
	end
	initial begin
		#(WDOG_NS);
		n_fail++;
		tally_and_finish();
	end
endmodule
